// ### logic/dsb_cfg.svh
/*
 * Debug state and breakpoint block: offsets, field positions, reset values, timing counts.
 * Assumes inclusion by the design module only.
 */
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH

// debug register window (present only while background mode is active)
`define DSB_OFS_INSTR        16'hFF00
`define DSB_OFS_FLAGS        16'hFF01
`define DSB_OFS_SHIFT_HI     16'hFF02
`define DSB_OFS_SHIFT_LO     16'hFF03
`define DSB_OFS_ADDR_HI      16'hFF04
`define DSB_OFS_ADDR_LO      16'hFF05
`define DSB_OFS_CCR          16'hFF06
`define DSB_ROM_BASE         16'hFF20

// breakpoint setup registers, always mapped
`define DSB_OFS_BPCTL0       16'h0020
`define DSB_OFS_BPCTL1       16'h0021
`define DSB_OFS_BPAH         16'h0022
`define DSB_OFS_BPAL         16'h0023
`define DSB_OFS_BPDH         16'h0024
`define DSB_OFS_BPDL         16'h0025

// status register bit positions
`define DSB_BIT_PERMIT       7
`define DSB_BIT_ACTIVE       6
`define DSB_BIT_TAGEN        5
`define DSB_BIT_SVALID       4
`define DSB_BIT_STEP         3

// control register 0 bit positions
`define DSB_BIT_MODE_HI      7
`define DSB_BIT_MODE_LO      6
`define DSB_BIT_PROGONLY     5
`define DSB_BIT_BP1ALE       3
`define DSB_BIT_BP0ALE       2

// control register 1 bit positions
`define DSB_BIT_SECOND       6
`define DSB_BIT_MASKH        5
`define DSB_BIT_MASKL        4
`define DSB_BIT_RW1E         3
`define DSB_BIT_RW1          2
`define DSB_BIT_RW0E         1
`define DSB_BIT_RW0          0

`define DSB_RST_ZERO8        8'h00
`define DSB_RST_ZERO16       16'h0000
`define DSB_NEXT_STEP        16'h0002

// delays in clock cycles
`define DSB_ACTIVE_WR_DLY    4
`define DSB_TAG_EN_DLY       16

`endif

// ### logic/dsb_pkg.sv
/*
 * Types shared by the debug state and breakpoint block.
 * Assumes dsb_cfg.svh is on the include path.
 */
package dsb_pkg;

    typedef enum logic [2:0] {
        DSB_SEL_NONE0 = 3'h0,
        DSB_SEL_NONE1 = 3'h1,
        DSB_SEL_NEXT  = 3'h2,
        DSB_SEL_PC    = 3'h3,
        DSB_SEL_D     = 3'h4,
        DSB_SEL_X     = 3'h5,
        DSB_SEL_Y     = 3'h6,
        DSB_SEL_SP    = 3'h7
    } dsb_regsel_t;

    typedef enum logic [1:0] {
        DSB_BP_OFF     = 2'h0,
        DSB_BP_SWIDUAL = 2'h1,
        DSB_BP_FULL    = 2'h2,
        DSB_BP_BDMDUAL = 2'h3
    } dsb_bpmode_t;

    // one CPU bus cycle as seen by the comparator
    typedef struct packed {
        logic        valid;
        logic        progFetch;
        logic        read;
        logic [15:0] addr;
        logic [15:0] data;
    } dsb_buscyc_t;

    // one-hot decode of the register-select field
    typedef struct packed {
        logic next;
        logic pc;
        logic d;
        logic x;
        logic y;
        logic sp;
    } dsb_regdec_t;

    typedef enum logic [2:0] {
        DSB_TAG_IDLE = 3'b001,
        DSB_TAG_WAIT = 3'b010,
        DSB_TAG_ON   = 3'b100
    } dsb_tagst_t;

endpackage

// ### logic/dsb_debug_core.sv
/*
 * Debug state flags, serial shift word, address hold, saved condition codes
 * and the hardware breakpoint comparator.
 * Assumes a CPU register port (addr/wr/rd, 8-bit data, combinational read
 * captured into a flop), firmware/serial strobes from the debug unit, and a
 * bus-cycle monitor stream from the core on the same clock.
 */
`timescale 1ns/1ns
`include "dsb_cfg.svh"

module dsb_debug_core
    import dsb_pkg::*;
#(
    parameter int ACTIVE_DLY = `DSB_ACTIVE_WR_DLY,
    parameter int TAG_DLY    = `DSB_TAG_EN_DLY
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        porRst_n,
    input  wire logic        specialMode,
    input  wire logic [15:0] regAddr,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    output logic             regHit,
    input  wire logic        fwCmdValid,
    input  wire logic [7:0]  fwCmd,
    input  wire logic [15:0] xIndex,
    output logic      [15:0] nextAddr,
    output logic      [5:0]  regSelect,
    input  wire logic        enterBdm,
    input  wire logic        stepCmd,
    input  wire logic        tagGoCmd,
    input  wire logic [7:0]  cpuCcr,
    input  wire logic        shiftLoad,
    input  wire logic [15:0] shiftIn,
    input  wire logic        shiftDone,
    input  wire logic        hwAddrLoad,
    input  wire logic [15:0] hwAddr,
    input  wire dsb_buscyc_t busCyc,
    input  wire logic        tagExecuted,
    output logic             bdmMapped,
    output logic             tagging,
    output logic             serialEnable,
    output logic             bpTagReq,
    output logic             swiReq,
    output logic             bdmBreakReq
);

    logic        permit_r;
    logic        active_r;
    logic        tagEn_r;
    logic        sValid_r;
    logic        step_r;
    logic [15:0] shift_r;
    logic [15:0] addrHold_r;
    logic [7:0]  ccrSave_r;
    logic [7:0]  ctl0_r;
    logic [7:0]  ctl1_r;
    logic [15:0] bpAddr_r;
    logic [15:0] bpData_r;
    logic [2:0]  actPipeVal_r [ACTIVE_DLY];
    logic [ACTIVE_DLY-1:0] actPipeV_r;
    logic [4:0]  tagCnt_r;
    dsb_tagst_t  tagSt_r;
    dsb_regdec_t dec;
    logic        wrFlags;
    logic        dbgHit;
    logic        bpHit;

    assign dbgHit = active_r && (regAddr >= `DSB_OFS_INSTR) && (regAddr <= `DSB_OFS_CCR);
    assign bpHit  = (regAddr >= `DSB_OFS_BPCTL0) && (regAddr <= `DSB_OFS_BPDL);
    assign wrFlags = regWr && dbgHit && (regAddr == `DSB_OFS_FLAGS);

    always_comb begin
        dec = '0;
        unique case (dsb_regsel_t'(fwCmd[2:0]))
            DSB_SEL_NEXT: dec.next = 1'b1;
            DSB_SEL_PC:   dec.pc   = 1'b1;
            DSB_SEL_D:    dec.d    = 1'b1;
            DSB_SEL_X:    dec.x    = 1'b1;
            DSB_SEL_Y:    dec.y    = 1'b1;
            DSB_SEL_SP:   dec.sp   = 1'b1;
            DSB_SEL_NONE0, DSB_SEL_NONE1: dec = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regSelect <= 6'h00;
            nextAddr  <= `DSB_RST_ZERO16;
        end else if (fwCmdValid && !tagging) begin
            regSelect <= dec;
            if (dec.next) begin
                nextAddr <= xIndex + `DSB_NEXT_STEP;
            end
        end
    end

    // permit: firmware sets it; special modes cause firmware to set it early
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            permit_r <= 1'b0;
        end else if (wrFlags) begin
            permit_r <= regWdata[`DSB_BIT_PERMIT];
        end
    end

    // active flag writes pass a fixed delay line
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            actPipeV_r <= '0;
        end else begin
            actPipeV_r <= {actPipeV_r[ACTIVE_DLY-2:0], wrFlags};
        end
    end

    always_ff @(posedge clk) begin
        actPipeVal_r[0] <= {2'b00, regWdata[`DSB_BIT_ACTIVE]};
        for (int i = 1; i < ACTIVE_DLY; i++) begin
            actPipeVal_r[i] <= actPipeVal_r[i-1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // special modes come out of reset active
            active_r <= specialMode;
        end else if (enterBdm && permit_r) begin
            active_r <= 1'b1;
        end else if (actPipeV_r[ACTIVE_DLY-1]) begin
            active_r <= actPipeVal_r[ACTIVE_DLY-1][0];
        end
    end

    // tag enable set by tag-and-resume, cleared on entry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tagEn_r <= 1'b0;
        end else if (tagGoCmd) begin
            // set wins over the entry clear in the same cycle
            tagEn_r <= 1'b1;
        end else if (enterBdm && permit_r) begin
            tagEn_r <= 1'b0;
        end else if (wrFlags) begin
            tagEn_r <= regWdata[`DSB_BIT_TAGEN];
        end
    end

    // tagging starts after the tag enable delay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tagSt_r  <= DSB_TAG_IDLE;
            tagCnt_r <= 5'h00;
        end else begin
            unique case (tagSt_r)
                DSB_TAG_IDLE: begin
                    if (tagGoCmd || (wrFlags && regWdata[`DSB_BIT_TAGEN])) begin
                        tagSt_r  <= DSB_TAG_WAIT;
                        tagCnt_r <= 5'(TAG_DLY - 1);
                    end
                end
                DSB_TAG_WAIT: begin
                    if (!tagEn_r) begin
                        tagSt_r <= DSB_TAG_IDLE;
                    end else if (tagCnt_r == 5'h00) begin
                        tagSt_r <= DSB_TAG_ON;
                    end else begin
                        tagCnt_r <= tagCnt_r - 5'h01;
                    end
                end
                DSB_TAG_ON: begin
                    if (!tagEn_r) begin
                        tagSt_r <= DSB_TAG_IDLE;
                    end
                end
                default: tagSt_r <= DSB_TAG_IDLE;
            endcase
        end
    end

    // serial link shut off while tagging
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tagging      <= 1'b0;
            serialEnable <= 1'b1;
        end else begin
            tagging      <= (tagSt_r == DSB_TAG_ON) && tagEn_r;
            serialEnable <= !((tagSt_r == DSB_TAG_ON) && tagEn_r);
        end
    end

    // valid set on load, hardware set wins over completion clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sValid_r <= 1'b0;
        end else if (shiftLoad) begin
            sValid_r <= 1'b1;
        end else if (shiftDone) begin
            sValid_r <= 1'b0;
        end
    end

    // single-step flag; the command wins over a firmware clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_r <= 1'b0;
        end else if (stepCmd) begin
            step_r <= 1'b1;
        end else if (wrFlags) begin
            step_r <= regWdata[`DSB_BIT_STEP];
        end
    end

    // shift word, serial load or firmware byte writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_r <= `DSB_RST_ZERO16;
        end else if (shiftLoad) begin
            shift_r <= shiftIn;
        end else if (regWr && dbgHit && regAddr == `DSB_OFS_SHIFT_HI) begin
            shift_r[15:8] <= regWdata;
        end else if (regWr && dbgHit && regAddr == `DSB_OFS_SHIFT_LO) begin
            shift_r[7:0] <= regWdata;
        end
    end

    // address hold loaded by hardware only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addrHold_r <= `DSB_RST_ZERO16;
        end else if (hwAddrLoad) begin
            addrHold_r <= hwAddr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ccrSave_r <= `DSB_RST_ZERO8;
        end else if (enterBdm && permit_r) begin
            ccrSave_r <= cpuCcr;
        end else if (regWr && dbgHit && regAddr == `DSB_OFS_CCR) begin
            ccrSave_r <= regWdata;
        end
    end

    // breakpoint control follows normal reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl0_r <= `DSB_RST_ZERO8;
            ctl1_r <= `DSB_RST_ZERO8;
        end else if (regWr && regAddr == `DSB_OFS_BPCTL0) begin
            ctl0_r <= regWdata & 8'hEC;
        end else if (regWr && regAddr == `DSB_OFS_BPCTL1) begin
            ctl1_r <= regWdata & 8'h7F;
        end
    end

    always_ff @(posedge clk) begin
        if (!porRst_n) begin
            bpAddr_r <= `DSB_RST_ZERO16;
            bpData_r <= `DSB_RST_ZERO16;
        end else if (regWr) begin
            if (regAddr == `DSB_OFS_BPAH) bpAddr_r[15:8] <= regWdata;
            if (regAddr == `DSB_OFS_BPAL) bpAddr_r[7:0]  <= regWdata;
            if (regAddr == `DSB_OFS_BPDH) bpData_r[15:8] <= regWdata;
            if (regAddr == `DSB_OFS_BPDL) bpData_r[7:0]  <= regWdata;
        end
    end

    // register read mux, captured for a flopped output
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        unique case (regAddr)
            `DSB_OFS_FLAGS:    rdMux = {permit_r, active_r, tagEn_r, sValid_r, step_r, 3'h0};
            `DSB_OFS_SHIFT_HI: rdMux = shift_r[15:8];
            `DSB_OFS_SHIFT_LO: rdMux = shift_r[7:0];
            `DSB_OFS_ADDR_HI:  rdMux = addrHold_r[15:8];
            `DSB_OFS_ADDR_LO:  rdMux = addrHold_r[7:0];
            `DSB_OFS_CCR:      rdMux = ccrSave_r;
            `DSB_OFS_BPCTL0:   rdMux = ctl0_r;
            `DSB_OFS_BPCTL1:   rdMux = ctl1_r;
            `DSB_OFS_BPAH:     rdMux = bpAddr_r[15:8];
            `DSB_OFS_BPAL:     rdMux = bpAddr_r[7:0];
            `DSB_OFS_BPDH:     rdMux = bpData_r[15:8];
            `DSB_OFS_BPDL:     rdMux = bpData_r[7:0];
            default:           rdMux = 8'h00;
        endcase
        if (!dbgHit && !bpHit) begin
            rdMux = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata  <= 8'h00;
            regHit    <= 1'b0;
            bdmMapped <= 1'b0;
        end else begin
            regRdata  <= regRd ? rdMux : 8'h00;
            regHit    <= (regRd || regWr) && (dbgHit || bpHit || (active_r && regAddr >= `DSB_ROM_BASE));
            bdmMapped <= active_r;
        end
    end

    // comparator
    dsb_bpmode_t mode;
    logic progOnly, dual, hit0, hit1, dataHit, rw0Ok, rw1Ok, anyHit;
    assign mode     = dsb_bpmode_t'(ctl0_r[`DSB_BIT_MODE_HI:`DSB_BIT_MODE_LO]);
    assign dual     = (mode == DSB_BP_SWIDUAL) || (mode == DSB_BP_BDMDUAL);
    assign progOnly = ctl0_r[`DSB_BIT_PROGONLY] || (mode == DSB_BP_SWIDUAL);

    assign rw0Ok = progOnly || (mode == DSB_BP_SWIDUAL) || !ctl1_r[`DSB_BIT_RW0E]
                   || (busCyc.read == ctl1_r[`DSB_BIT_RW0]);
    assign rw1Ok = progOnly || !ctl1_r[`DSB_BIT_RW1E] || (busCyc.read == ctl1_r[`DSB_BIT_RW1]);

    always_comb begin
        // upper byte always, low byte only when enabled
        // address registers against the address bus
        hit0 = (busCyc.addr[15:8] == bpAddr_r[15:8])
               && (!ctl0_r[`DSB_BIT_BP0ALE] || busCyc.addr[7:0] == bpAddr_r[7:0]) && rw0Ok;
        // second address from the data registers
        hit1 = dual && ctl1_r[`DSB_BIT_SECOND]
               && (busCyc.addr[15:8] == bpData_r[15:8])
               && (!ctl0_r[`DSB_BIT_BP1ALE] || busCyc.addr[7:0] == bpData_r[7:0]) && rw1Ok;
        // data compare with byte masks when the second bit is set, unless program-only
        dataHit = progOnly || !ctl1_r[`DSB_BIT_SECOND]
                  || ((ctl1_r[`DSB_BIT_MASKH] || busCyc.data[15:8] == bpData_r[15:8])
                      && (ctl1_r[`DSB_BIT_MASKL] || busCyc.data[7:0] == bpData_r[7:0]));
        unique case (mode)
            DSB_BP_OFF:  anyHit = 1'b0;
            DSB_BP_FULL: anyHit = hit0 && dataHit;
            DSB_BP_SWIDUAL, DSB_BP_BDMDUAL: anyHit = hit0 || hit1;
        endcase
        if (progOnly && !busCyc.progFetch) anyHit = 1'b0;
        // one evaluation per valid bus cycle
        if (!busCyc.valid) anyHit = 1'b0;
        if (active_r) anyHit = 1'b0;
    end

    // program-only hits tag the fetch; the break waits for execution
    // debug-entry requests only while permit is high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bpTagReq    <= 1'b0;
            swiReq      <= 1'b0;
            bdmBreakReq <= 1'b0;
        end else begin
            bpTagReq    <= anyHit && progOnly;
            swiReq      <= (mode == DSB_BP_SWIDUAL) && tagExecuted && !active_r;
            bdmBreakReq <= (mode[1] && permit_r && !active_r)
                           && ((anyHit && !progOnly) || (progOnly && tagExecuted));
        end
    end

    chk_bp_quiet_active: assert property (@(posedge clk) disable iff (!rst_n)
        active_r |=> !bdmBreakReq && !bpTagReq && !swiReq)
        else $error("breakpoint request while active");

    chk_bdm_needs_permit: assert property (@(posedge clk) disable iff (!rst_n)
        bdmBreakReq |-> $past(permit_r))
        else $error("debug break without permit");

    // tagging needs 16 cycles after the command; checked here for the first 8 only
    sequence tagStart_s;
        tagGoCmd && !tagEn_r && tagSt_r == DSB_TAG_IDLE;
    endsequence
    chk_tag_delay_min: assert property (@(posedge clk) disable iff (!rst_n)
        tagStart_s |=> !tagging [*8])
        else $error("tagging started too early");

    chk_serial_off_tag: assert property (@(posedge clk) disable iff (!rst_n)
        tagging |-> !serialEnable)
        else $error("serial enabled during tagging");

    // active follows a flag write after the delay
    chk_active_wr_dly: assert property (@(posedge clk) disable iff (!rst_n)
        (wrFlags && !regWdata[`DSB_BIT_ACTIVE] && !enterBdm) ##1 !enterBdm [*4] |=> !active_r)
        else $error("active flag write delay wrong");

    // saved flags equal the condition codes after entry
    chk_ccr_capture: assert property (@(posedge clk) disable iff (!rst_n)
        enterBdm && permit_r |=> ccrSave_r == $past(cpuCcr))
        else $error("condition codes not captured");

    chk_step_set: assert property (@(posedge clk) disable iff (!rst_n)
        stepCmd |=> step_r)
        else $error("single-step flag not set");

    chk_no_entry_unpermit: assert property (@(posedge clk) disable iff (!rst_n)
        !active_r && !permit_r && !actPipeV_r[ACTIVE_DLY-1] |=> !active_r)
        else $error("active entered without permit");

    // next address is X plus two
    chk_next_addr: assert property (@(posedge clk) disable iff (!rst_n)
        fwCmdValid && !tagging && fwCmd[2:0] == 3'h2 |=> nextAddr == $past(xIndex) + 16'h0002)
        else $error("next address not X plus two");

endmodule

// ### testbench/dsb_host_model.sv
/*
 * Host side of the serial link: loads shift words after a lag, ends them.
 * Assumes the bench pulses sendReq and endReq on the design clock.
 */
`timescale 1ns/1ns
module dsb_host_model (
    input  wire logic        clk,
    input  wire logic        sendReq,
    input  wire logic [15:0] sendWord,
    input  wire logic [3:0]  lag,
    input  wire logic        endReq,
    output logic             shiftLoad,
    output logic      [15:0] shiftIn,
    output logic             shiftDone
);
    int cnt;
    initial begin
        cnt = -1;
        shiftLoad = 1'b0;
        shiftIn = 16'h0000;
        shiftDone = 1'b0;
    end
    // only shift words, no next-word writes
    always @(posedge clk) begin
        shiftLoad <= (cnt == 0);
        shiftDone <= endReq;
        // after its load cycle a released word toggles to its inverse each cycle
        shiftIn <= (cnt == 0) ? sendWord : ~shiftIn;
        cnt <= sendReq ? int'(lag) : ((cnt >= 0) ? cnt - 1 : -1);
    end
endmodule

// ### testbench/dsb_debug_core_tb.sv
/*
 * Bench for the debug state and breakpoint block.
 * Assumes dsb_pkg and dsb_host_model are compiled first.
 */
`timescale 1ns/1ns
module dsb_debug_core_tb
    import dsb_pkg::*;
;
    localparam int TD = 16;
    logic        clk = 1'b0;
    logic        rst_n, porRst_n, specialMode, regWr, regRd, regHit, fwCmdValid;
    logic        enterBdm, stepCmd, tagGoCmd, shiftLoad, shiftDone, hwAddrLoad;
    logic        tagExecuted, bdmMapped, tagging, serialEnable, bpTagReq, swiReq;
    logic        bdmBreakReq, sendReq, endReq;
    logic [15:0] regAddr, xIndex, hwAddr, shiftIn, nextAddr, sendWord;
    logic [7:0]  regWdata, regRdata, fwCmd, cpuCcr;
    logic [5:0]  regSelect;
    logic [3:0]  lag;
    dsb_buscyc_t busCyc;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          i;

    dsb_debug_core i_dut (.clk, .rst_n, .porRst_n, .specialMode, .regAddr,
        .regWr, .regRd, .regWdata, .regRdata, .regHit, .fwCmdValid, .fwCmd, .xIndex, .nextAddr,
        .regSelect, .enterBdm, .stepCmd, .tagGoCmd, .cpuCcr, .shiftLoad, .shiftIn, .shiftDone,
        .hwAddrLoad, .hwAddr, .busCyc, .tagExecuted, .bdmMapped, .tagging, .serialEnable,
        .bpTagReq, .swiReq, .bdmBreakReq);
    dsb_host_model i_host (.clk, .sendReq, .sendWord, .lag, .endReq, .shiftLoad, .shiftIn,
        .shiftDone);

    always #10 clk = ~clk;

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // each access ends with an idle cycle so strobes never toggle twice at once
    task wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        cyc(1);
        regWr = 1'b0;
        cyc(1);
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e, input logic h);
        regAddr = a;
        regRd = 1'b1;
        cyc(1);
        regRd = 1'b0;
        chk(regRdata, e);
        chk(regHit, h);
        cyc(1);
    endtask
    // expected order: tag request, interrupt, debug break
    task bus(input logic [15:0] a, input logic f, input logic r, input logic [2:0] e);
        busCyc = '{1'b1, f, r, a, 16'h0000};
        cyc(1);
        busCyc.valid = 1'b0;
        chk({bpTagReq, swiReq, bdmBreakReq}, e);
        cyc(1);
    endtask

    initial begin
        {rst_n, porRst_n, regWr, regRd, fwCmdValid, enterBdm, stepCmd, tagGoCmd} = '0;
        {hwAddrLoad, tagExecuted, sendReq, endReq, lag} = '0;
        {regAddr, xIndex, hwAddr, sendWord, regWdata, fwCmd, cpuCcr} = '0;
        busCyc = '0;
        specialMode = 1'b1;
        cyc(4);
        rst_n = 1'b1;
        porRst_n = 1'b1;
        rd(16'hFF01, 8'h40, 1'b1);
        wr(16'hFF01, 8'hC0);
        rd(16'hFF01, 8'hC0, 1'b1);
        sendWord = 16'hA55A;
        lag = 4'h3;
        sendReq = 1'b1;
        cyc(1);
        sendReq = 1'b0;
        cyc(6);
        rd(16'hFF01, 8'hD0, 1'b1);
        rd(16'hFF02, 8'hA5, 1'b1);
        rd(16'hFF03, 8'h5A, 1'b1);
        endReq = 1'b1;
        cyc(1);
        endReq = 1'b0;
        cyc(2);
        rd(16'hFF01, 8'hC0, 1'b1);
        wr(16'hFF02, 8'h3C);
        rd(16'hFF02, 8'h3C, 1'b1);
        hwAddr = 16'hBEEF;
        hwAddrLoad = 1'b1;
        cyc(1);
        hwAddrLoad = 1'b0;
        wr(16'hFF04, 8'h00);
        rd(16'hFF04, 8'hBE, 1'b1);
        rd(16'hFF05, 8'hEF, 1'b1);
        cpuCcr = 8'h5A;
        enterBdm = 1'b1;
        cyc(1);
        enterBdm = 1'b0;
        cyc(1);
        rd(16'hFF06, 8'h5A, 1'b1);
        wr(16'hFF06, 8'h11);
        rd(16'hFF06, 8'h11, 1'b1);
        rd(16'hFF20, 8'h00, 1'b1);
        xIndex = 16'h1234;
        for (i = 0; i < 8; i++) begin
            fwCmd = 8'h60 | 8'(i);
            fwCmdValid = 1'b1;
            cyc(1);
            fwCmdValid = 1'b0;
            chk(regSelect, (i < 2) ? 16'h0000 : (16'h0020 >> (i - 2)));
            cyc(1);
        end
        chk(nextAddr, 16'h1236);
        tagGoCmd = 1'b1;
        cyc(1);
        tagGoCmd = 1'b0;
        cyc(TD);
        chk(tagging, 1'b0);
        cyc(1);
        chk(tagging, 1'b1);
        chk(serialEnable, 1'b0);
        rd(16'hFF01, 8'hE0, 1'b1);
        fwCmd = 8'h63;
        fwCmdValid = 1'b1;
        cyc(1);
        fwCmdValid = 1'b0;
        chk(regSelect, 16'h0001);
        enterBdm = 1'b1;
        cyc(1);
        enterBdm = 1'b0;
        stepCmd = 1'b1;
        cyc(1);
        stepCmd = 1'b0;
        rd(16'hFF01, 8'hC8, 1'b1);
        wr(16'hFF01, 8'h80);
        cyc(3);
        chk(bdmMapped, 1'b1);
        cyc(1);
        chk(bdmMapped, 1'b0);
        rd(16'hFF01, 8'h00, 1'b0);
        rd(16'h0020, 8'h00, 1'b1);
        wr(16'h0022, 8'h12);
        wr(16'h0023, 8'h34);
        wr(16'h0020, 8'h84);
        bus(16'h1234, 1'b0, 1'b1, 3'b001);
        bus(16'h1235, 1'b0, 1'b1, 3'b000);
        wr(16'h0020, 8'h80);
        bus(16'h12FF, 1'b0, 1'b1, 3'b001);
        wr(16'h0021, 8'h03);
        bus(16'h1234, 1'b0, 1'b0, 3'b000);
        bus(16'h1234, 1'b0, 1'b1, 3'b001);
        wr(16'h0020, 8'h44);
        bus(16'h1234, 1'b1, 1'b0, 3'b100);
        tagExecuted = 1'b1;
        cyc(1);
        tagExecuted = 1'b0;
        chk(swiReq, 1'b1);
        wr(16'h0020, 8'hA4);
        bus(16'h1234, 1'b0, 1'b1, 3'b000);
        bus(16'h1234, 1'b1, 1'b1, 3'b100);
        tagExecuted = 1'b1;
        cyc(1);
        tagExecuted = 1'b0;
        chk(bdmBreakReq, 1'b1);
        // bus data is 0000 against a data word of 5600
        wr(16'h0024, 8'h56);
        wr(16'h0020, 8'h84);
        wr(16'h0021, 8'h43);
        bus(16'h1234, 1'b0, 1'b1, 3'b000);
        wr(16'h0021, 8'h63);
        bus(16'h1234, 1'b0, 1'b1, 3'b001);
        wr(16'h0020, 8'hC0);
        bus(16'h56AB, 1'b0, 1'b1, 3'b001);
        wr(16'h0021, 8'h03);
        bus(16'h56AB, 1'b0, 1'b1, 3'b000);
        wr(16'h0020, 8'h00);
        bus(16'h1234, 1'b1, 1'b1, 3'b000);
        enterBdm = 1'b1;
        cyc(1);
        enterBdm = 1'b0;
        wr(16'h0020, 8'h84);
        bus(16'h1234, 1'b0, 1'b1, 3'b000);
        rst_n = 1'b0;
        specialMode = 1'b0;
        cyc(4);
        rst_n = 1'b1;
        rd(16'h0022, 8'h12, 1'b1);
        rd(16'h0024, 8'h56, 1'b1);
        rd(16'hFF01, 8'h00, 1'b0);
        enterBdm = 1'b1;
        cyc(1);
        enterBdm = 1'b0;
        cyc(3);
        chk(bdmMapped, 1'b0);
        give_verdict();
    end
endmodule
